// >>> cpu_core_model.sv
// CPU core model facing the interrupt controller's request output.
// Assumes requests are sampled on rising core_clk edges.
`timescale 1ns/10ps
module cpu_core_model (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       irq_req,
	input  wire logic [5:0] requested_priority,
	input  wire logic [5:0] base_pri,
	input  wire logic       accept,
	output logic      [5:0] current_cpu_priority
);
	// Takes a request only when it outranks the running priority
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			current_cpu_priority <= 6'h00;
		else if (!accept)
			current_cpu_priority <= base_pri;
		else if (irq_req && (requested_priority > current_cpu_priority))
			current_cpu_priority <= requested_priority;
	end
endmodule

// >>> edge_if.sv
// Carrier between the controller core and one edge detector.
// Assumes the core drives pin level and polarity and reads the pulse.
`timescale 1ns/10ps
interface edge_if;
	logic raw;
	logic polarity;
	logic pulse;

	modport det (input raw, input polarity, output pulse);
	modport user (output raw, output polarity, input pulse);
endinterface

// >>> ext_edge_detect.sv
// Synchroniser and polarity-selected edge detector for one request pin.
// Assumes the pin is asynchronous to core_clk; pulse lasts one cycle.
`timescale 1ns/10ps
module ext_edge_detect (
	input  wire logic core_clk,
	input  wire logic resetn,
	edge_if.det       e
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
	} det_s;

	localparam det_s DET_RST = '0;

	det_s st;
	det_s next_st;

	// ----------------------------------------------------------------
	// Synchronise, then compare with the previous sample
	// ----------------------------------------------------------------
	always_comb begin
		next_st       = st;
		next_st.sync1 = e.raw;
		next_st.sync2 = st.sync1;
		next_st.prev  = st.sync2;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= DET_RST;
		end else begin
			st <= next_st;
		end
	end

	// High polarity selects rising transitions, low selects falling
	assign e.pulse = (st.sync2 != st.prev) && (st.sync2 == e.polarity);

	AST_EDGE_POLARITY: assert property (@(posedge core_clk) disable iff (!resetn)
		e.pulse |-> st.sync2 == e.polarity && $past(st.sync2) != st.sync2)
		else $error("edge pulse without a transition of the selected polarity");

endmodule

// >>> irq_coalesce_core.sv
// Interrupt controller core: five edge-triggered external requests,
// vectored dispatch, temporal-proximity coalescing and SLEEP wake decisions.
// Assumes control inputs are on core_clk; request pins are asynchronous.
//
// Overview of operation
// - Five external inputs raise a request only on a transition, never a level.
// - Control bits 4:0 pick rising or falling edge per input.
// - Multi-vector mode gives each request its own computed vector address.
// - Multi-vector mode selects shadow register set for priority 7 only.
// - Request to CPU as soon as pending priority exceeds CPU priority.
// - Control bits 10:8 give threshold priority that starts the window timer.
// - Each qualifying request reloads the window timer from the reload value.
// - After loading, the timer read returns the live count.
// - While the window runs, requests at or below threshold are held.
// - At timer zero held requests go out if above CPU priority.
// - Threshold zero disables window loads and hold-off; a running count still steps to zero.
// - The reload value is a full 32-bit quantity kept whole.
// - Every controller register returns to reset on any device reset.
// - In SLEEP only sources running in SLEEP are considered, and may wake.
// - In SLEEP a disabled or priority-zero request sets its flag but leaves the power state unchanged.
// - In SLEEP a request above CPU priority wakes to RUN and is served.
// - In SLEEP a held request keeps SLEEP until the timer expires.
// - In SLEEP a request at or below CPU priority moves to IDLE.
`timescale 1ns/10ps
module irq_coalesce_core (
	input  wire logic                                         core_clk,
	input  wire logic                                         resetn,
	input  wire logic [irq_coalesce_pkg::NUM_SRC-1:0]         external_request_inputs,
	input  wire logic [irq_coalesce_pkg::CTL_W-1:0]           irq_control_reg,
	input  wire logic                                         multi_vector,
	input  wire logic                                         single_vec_shadow,
	input  wire logic [31:0]                                  vector_base,
	input  wire logic [irq_coalesce_pkg::NUM_SRC-1:0]         src_enable,
	input  wire logic [irq_coalesce_pkg::NUM_SRC*irq_coalesce_pkg::PRI_W-1:0] src_priority,
	input  wire logic [irq_coalesce_pkg::NUM_SRC-1:0]         flag_clear,
	input  wire logic                                         reload_wr,
	input  wire logic [irq_coalesce_pkg::TMR_W-1:0]           reload_data,
	input  wire logic [irq_coalesce_pkg::CPU_PRI_W-1:0]       current_cpu_priority,
	input  wire logic                                         sleep_enter,
	output logic      [irq_coalesce_pkg::NUM_SRC-1:0]         irq_flags,
	output logic                                              irq_req,
	output logic      [irq_coalesce_pkg::CPU_PRI_W-1:0]       requested_priority,
	output logic      [irq_coalesce_pkg::IDX_W-1:0]           vector_num,
	output logic      [31:0]                                  vector_addr,
	output logic                                              shadow_set,
	output irq_coalesce_pkg::power_e                          power_state,
	output logic      [irq_coalesce_pkg::TMR_W-1:0]           proximity_window_timer
);

	localparam int N  = irq_coalesce_pkg::NUM_SRC;
	localparam int PW = irq_coalesce_pkg::PRI_W;
	localparam int TW = irq_coalesce_pkg::TMR_W;

	typedef struct packed {
		logic [N-1:0]                             flag;
		logic [TW-1:0]                            reload;
		logic [TW-1:0]                            count;
		logic                                     loaded;
		logic                                     irq_req;
		logic [irq_coalesce_pkg::CPU_PRI_W-1:0]   req_pri;
		logic [irq_coalesce_pkg::IDX_W-1:0]       vec_num;
		logic [31:0]                              vec_addr;
		logic                                     shadow;
		irq_coalesce_pkg::power_e                 pwr;
		logic [TW-1:0]                            timer_read;
	} core_s;

	localparam core_s CORE_RST = '{
		flag:       '0,
		reload:     irq_coalesce_pkg::TMR_ZERO,
		count:      irq_coalesce_pkg::TMR_ZERO,
		loaded:     1'b0,
		irq_req:    1'b0,
		req_pri:    '0,
		vec_num:    '0,
		vec_addr:   32'h0,
		shadow:     1'b0,
		pwr:        irq_coalesce_pkg::PWR_RUN,
		timer_read: irq_coalesce_pkg::TMR_ZERO
	};

	core_s        st;
	core_s        next_st;
	logic [N-1:0] pulse;
	logic [PW-1:0] thr;
	logic [PW-1:0] best_pri;
	logic [irq_coalesce_pkg::IDX_W-1:0] best_idx;
	logic         any_pend;
	logic         load;
	logic         hold;
	logic         deliver;

	assign thr = irq_control_reg[irq_coalesce_pkg::TPC_LSB +: PW];

	// ----------------------------------------------------------------
	// Edge detectors, one per external request pin
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < N; i++) begin : g_src
			edge_if e ();
			assign e.raw      = external_request_inputs[i];
			assign e.polarity = irq_control_reg[irq_coalesce_pkg::EP_LSB + i];
			assign pulse[i]   = e.pulse;
			ext_edge_detect u_det (
				.core_clk (core_clk),
				.resetn   (resetn),
				.e        (e.det)
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Arbitration, coalescing window and power decisions
	// ----------------------------------------------------------------
	always_comb begin
		logic [PW-1:0] p;
		logic          cand;
		p        = '0;
		cand     = 1'b0;
		next_st  = st;
		best_pri = irq_coalesce_pkg::PRI_NONE;
		best_idx = '0;
		any_pend = 1'b0;
		load     = 1'b0;
		for (int i = 0; i < N; i++) begin
			p    = src_priority[i*PW +: PW];
			cand = st.flag[i] && src_enable[i]
				&& (p != irq_coalesce_pkg::PRI_NONE)
				&& (st.pwr != irq_coalesce_pkg::PWR_SLEEP
				|| irq_coalesce_pkg::SLEEP_OK[i]);
			// Lowest index wins among equal priorities
			if (cand && (!any_pend || p > best_pri)) begin
				best_pri = p;
				best_idx = i[irq_coalesce_pkg::IDX_W-1:0];
				any_pend = 1'b1;
			end
			// A fresh edge at or below the threshold restarts the window
			if (pulse[i] && src_enable[i] && p != irq_coalesce_pkg::PRI_NONE
				&& p <= thr && thr != irq_coalesce_pkg::TPC_OFF) begin
				load = 1'b1;
			end
		end

		hold = (thr != irq_coalesce_pkg::TPC_OFF)
			&& (st.count != irq_coalesce_pkg::TMR_ZERO || load)
			&& (best_pri <= thr);
		deliver = any_pend && !hold
			&& ({3'h0, best_pri} > current_cpu_priority);

		// Set wins over a clear arriving in the same cycle
		next_st.flag = (st.flag & ~flag_clear) | pulse;

		if (reload_wr) begin
			next_st.reload = reload_data;
		end
		if (load) begin
			next_st.count  = st.reload;
			next_st.loaded = 1'b1;
		end else if (st.count != irq_coalesce_pkg::TMR_ZERO) begin
			next_st.count = st.count - irq_coalesce_pkg::TMR_STEP;
		end
		next_st.timer_read = next_st.loaded ? next_st.count : next_st.reload;

		next_st.irq_req  = deliver;
		next_st.req_pri  = {3'h0, best_pri};
		next_st.vec_num  = best_idx;
		next_st.vec_addr = multi_vector
			? vector_base + ({29'h0, best_idx} << irq_coalesce_pkg::VEC_SHIFT)
			: vector_base;
		next_st.shadow   = multi_vector
			? (best_pri == irq_coalesce_pkg::PRI_SHADOW)
			: single_vec_shadow;

		case (st.pwr)
			irq_coalesce_pkg::PWR_RUN: begin
				if (sleep_enter) begin
					next_st.pwr = irq_coalesce_pkg::PWR_SLEEP;
				end
			end
			irq_coalesce_pkg::PWR_SLEEP: begin
				if (deliver) begin
					next_st.pwr = irq_coalesce_pkg::PWR_RUN;
				end else if (any_pend && !hold) begin
					next_st.pwr = irq_coalesce_pkg::PWR_IDLE;
				end
				// Held requests leave the state alone until expiry
			end
			irq_coalesce_pkg::PWR_IDLE: begin
				if (deliver) begin
					next_st.pwr = irq_coalesce_pkg::PWR_RUN;
				end
			end
			default: begin
				next_st.pwr = irq_coalesce_pkg::PWR_RUN;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st <= CORE_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign irq_flags              = st.flag;
	assign irq_req                = st.irq_req;
	assign requested_priority     = st.req_pri;
	assign vector_num             = st.vec_num;
	assign vector_addr            = st.vec_addr;
	assign shadow_set             = st.shadow;
	assign power_state            = st.pwr;
	assign proximity_window_timer = st.timer_read;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	AST_FLAG_NEEDS_EDGE: assert property (
		|(st.flag & ~$past(st.flag)) |-> $past(|pulse))
		else $error("flag set without an edge");

	AST_SET_BEATS_CLEAR: assert property (
		|(pulse & flag_clear) |=> |(st.flag & $past(pulse & flag_clear)))
		else $error("flag lost when set and clear coincide");

	AST_VECTOR_ADDR: assert property (
		irq_req && $past(multi_vector) |->
		vector_addr == $past(vector_base) + ({29'h0, vector_num} << 5))
		else $error("vector address not computed from source");

	AST_SHADOW_SET: assert property (
		irq_req && $past(multi_vector) |-> shadow_set == (requested_priority == 6'h7))
		else $error("register set selection wrong");

	AST_REQ_ABOVE_CPU: assert property (
		irq_req |-> requested_priority > $past(current_cpu_priority))
		else $error("request at or below cpu priority");

	AST_TIMER_LOAD: assert property (
		load && !reload_wr |=> st.count == $past(st.reload) && st.reload == $past(st.reload))
		else $error("timer not loaded from reload value");

	AST_LIVE_READ: assert property (
		st.loaded |-> proximity_window_timer == st.count)
		else $error("timer read not the live count");

	AST_HOLD_OFF: assert property (
		hold |=> !irq_req)
		else $error("request delivered inside window");

	AST_THR_OFF: assert property (
		thr == 3'h0 |-> !load && !hold)
		else $error("window active with threshold zero");

	AST_COUNT_DOWN: assert property (
		!load && st.count != 32'h0 |=> st.count == $past(st.count) - 32'h1)
		else $error("timer did not step down by one");

	AST_SLEEP_HELD: assert property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP && hold && !deliver
		|=> power_state == irq_coalesce_pkg::PWR_SLEEP)
		else $error("left sleep while held");

	AST_SLEEP_WAKE: assert property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP && deliver
		|=> power_state == irq_coalesce_pkg::PWR_RUN && irq_req)
		else $error("deliverable request did not wake to run");

	AST_SLEEP_IDLE: assert property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP && any_pend && !hold && !deliver
		|=> power_state == irq_coalesce_pkg::PWR_IDLE)
		else $error("low request did not move to idle");

	AST_SLEEP_IGNORE: assert property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP && !any_pend
		|=> power_state == irq_coalesce_pkg::PWR_SLEEP)
		else $error("ignored request changed power state");

	AST_RELOAD_KEPT: assert property (
		reload_wr |=> st.reload == $past(reload_data))
		else $error("reload value not stored whole");

	AST_PRELOAD_READ: assert property (
		!st.loaded |-> proximity_window_timer == st.reload)
		else $error("timer read not the reload value before first load");

	AST_SINGLE_VECTOR: assert property (
		irq_req && !$past(multi_vector) |->
		vector_addr == $past(vector_base) && shadow_set == $past(single_vec_shadow))
		else $error("single vector address or register set wrong");

	AST_WINDOW_RELEASE: assert property (
		st.count == irq_coalesce_pkg::TMR_ZERO && !load && any_pend
		&& ({3'h0, best_pri} > current_cpu_priority) |=> irq_req)
		else $error("queued request not released at timer zero");

	AST_FLAG_CLEARED: assert property (
		|(flag_clear & ~pulse) |=> (st.flag & $past(flag_clear & ~pulse)) == '0)
		else $error("flag survived a clear without a new edge");

	AST_COUNT_HOLDS_ZERO: assert property (
		!load && st.count == irq_coalesce_pkg::TMR_ZERO |=> st.count == irq_coalesce_pkg::TMR_ZERO)
		else $error("timer moved below zero");

	AST_NO_REQ_WHEN_EMPTY: assert property (
		!any_pend |=> !irq_req)
		else $error("request raised with no recognised source");

	AST_PRI_ZERO_NEVER: assert property (
		irq_req |-> requested_priority != 6'h0)
		else $error("priority zero request delivered");

	AST_IDLE_WAKE: assert property (
		st.pwr == irq_coalesce_pkg::PWR_IDLE && deliver
		|=> power_state == irq_coalesce_pkg::PWR_RUN && irq_req)
		else $error("deliverable request did not leave idle");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	COV_WINDOW_EXPIRY: cover property (
		st.count == 32'h1 && !load ##2 irq_req);
	COV_SLEEP_WAKE: cover property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP ##1 st.pwr == irq_coalesce_pkg::PWR_RUN);
	COV_SHADOW: cover property (irq_req && shadow_set && multi_vector);
	COV_SLEEP_IDLE: cover property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP ##1 st.pwr == irq_coalesce_pkg::PWR_IDLE);
	COV_HELD_IN_SLEEP: cover property (
		st.pwr == irq_coalesce_pkg::PWR_SLEEP && hold && any_pend);

endmodule

// >>> irq_coalesce_pkg.sv
// Constants and types shared by the self-checking bench and the
// coalescing interrupt controller core.
// Assumes a single 25 MHz system clock and an active-low asynchronous reset.
package irq_coalesce_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC   = 5;
	localparam int PRI_W     = 3;
	localparam int CPU_PRI_W = 6;
	localparam int TMR_W     = 32;
	localparam int CTL_W     = 11;
	localparam int IDX_W     = 3;

	// ----------------------------------------------------------------
	// Control word fields
	// ----------------------------------------------------------------
	localparam int EP_LSB  = 0;
	localparam int TPC_LSB = 8;

	// ----------------------------------------------------------------
	// Values
	// ----------------------------------------------------------------
	localparam logic [PRI_W-1:0] PRI_NONE     = 3'h0;
	localparam logic [PRI_W-1:0] PRI_SHADOW   = 3'h7;
	localparam logic [PRI_W-1:0] TPC_OFF      = 3'h0;
	localparam logic [TMR_W-1:0] TMR_ZERO     = 32'h0;
	localparam logic [TMR_W-1:0] TMR_STEP     = 32'h1;
	localparam int               VEC_SHIFT    = 5;
	localparam logic [NUM_SRC-1:0] SLEEP_OK   = 5'h1f;

	// Device power state, Gray along RUN -> SLEEP -> IDLE; both bits flip on IDLE -> RUN
	typedef enum logic [1:0] {
		PWR_RUN   = 2'h0,
		PWR_SLEEP = 2'h1,
		PWR_IDLE  = 2'h3
	} power_e;

endpackage

// >>> irq_edge_coalesce_sleep_wake_tb_top.sv
// Self-checking bench for the coalescing interrupt controller core.
// Assumes a 25 MHz core_clk; inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
module irq_edge_coalesce_sleep_wake_tb_top;
	logic        core_clk;
	logic        resetn;
	logic [4:0]  pins;
	logic [10:0] ctl;
	logic        multi_vector;
	logic        single_vec_shadow;
	logic [4:0]  src_enable;
	logic [14:0] src_priority;
	logic [4:0]  flag_clear;
	logic        reload_wr;
	logic [31:0] reload_data;
	logic        sleep_enter;
	logic [5:0]  base_pri;
	logic        accept;
	logic [5:0]  cpu_pri;
	logic [4:0]  irq_flags;
	logic        irq_req;
	logic [5:0]  req_pri;
	logic [2:0]  vector_num;
	logic [31:0] vector_addr;
	logic        shadow_set;
	irq_coalesce_pkg::power_e power_state;
	logic [31:0] timer;
	logic [31:0] t1;
	int          err_total;
	int          compares;

	irq_coalesce_core dut (.core_clk(core_clk), .resetn(resetn),
		.external_request_inputs(pins), .irq_control_reg(ctl),
		.multi_vector(multi_vector), .single_vec_shadow(single_vec_shadow),
		.vector_base(32'h0000_1000), .src_enable(src_enable),
		.src_priority(src_priority), .flag_clear(flag_clear), .reload_wr(reload_wr),
		.reload_data(reload_data), .current_cpu_priority(cpu_pri),
		.sleep_enter(sleep_enter), .irq_flags(irq_flags), .irq_req(irq_req),
		.requested_priority(req_pri), .vector_num(vector_num),
		.vector_addr(vector_addr), .shadow_set(shadow_set),
		.power_state(power_state), .proximity_window_timer(timer));

	cpu_core_model cpu (.core_clk(core_clk), .resetn(resetn), .irq_req(irq_req),
		.requested_priority(req_pri), .base_pri(base_pri), .accept(accept),
		.current_cpu_priority(cpu_pri));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Pulse a pin high then low, long enough for the synchroniser
	task automatic fire(input int i);
		pins[i] = 1'b1;
		tick(4);
		pins[i] = 1'b0;
		tick(4);
	endtask

	task automatic clr(input logic [4:0] m);
		flag_clear = m;
		tick(1);
		flag_clear = 5'h00;
		tick(2);
	endtask

	task automatic wait_req();
		int n;
		n = 0;
		while (irq_req !== 1'b1 && n < 80) begin
			tick(1);
			n++;
		end
	endtask

	task automatic go_sleep();
		sleep_enter = 1'b1;
		tick(1);
		sleep_enter = 1'b0;
		tick(1);
	endtask

	task automatic results();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		err_total++;
		results();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		resetn = 1'b0; pins = 5'h00; ctl = 11'h01f; multi_vector = 1'b1;
		single_vec_shadow = 1'b0; src_enable = 5'h00; src_priority = 15'h7d63;
		flag_clear = 5'h00; reload_wr = 1'b0; reload_data = 32'h0;
		sleep_enter = 1'b0; base_pri = 6'h00; accept = 1'b0;
		err_total = 0; compares = 0;
		tick(8);
		chk(irq_flags, 32'h0);
		chk(irq_req, 32'h0);
		chk(timer, 32'h0);
		chk(power_state, irq_coalesce_pkg::PWR_RUN);
		resetn = 1'b1;
		tick(2);
		src_enable = 5'h1f;
		// Source i has priority i+3; priority 7 picks the shadow set
		for (int i = 0; i < 5; i++) begin
			fire(i);
			chk(irq_req, 32'h1);
			chk(req_pri, i + 3);
			chk(vector_num, i);
			chk(vector_addr, 32'h0000_1000 + i * 32);
			chk(shadow_set, i == 4);
			clr(5'h1f);
			chk(irq_req, 32'h0);
		end
		// Disable, repolarise to falling, clear, re-enable
		src_enable = 5'h00;
		ctl[4:0] = 5'h00;
		clr(5'h1f);
		src_enable = 5'h1f;
		pins = 5'h1f;
		tick(6);
		chk(irq_flags, 32'h0);
		pins = 5'h00;
		tick(6);
		chk(irq_flags, 32'h1f);
		chk(vector_num, 32'h4);
		src_enable = 5'h00;
		ctl[4:0] = 5'h1f;
		clr(5'h1f);
		src_enable = 5'h1f;
		// Held off while the CPU runs at the same priority
		base_pri = 6'h05;
		fire(2);
		chk(irq_req, 32'h0);
		base_pri = 6'h04;
		tick(3);
		chk(irq_req, 32'h1);
		accept = 1'b1;
		tick(3);
		chk(cpu_pri, 32'h5);
		chk(irq_req, 32'h0);
		accept = 1'b0;
		base_pri = 6'h00;
		clr(5'h1f);
		multi_vector = 1'b0;
		single_vec_shadow = 1'b1;
		fire(1);
		chk(vector_addr, 32'h0000_1000);
		chk(shadow_set, 32'h1);
		multi_vector = 1'b1;
		clr(5'h1f);
		// Coalescing window
		reload_data = 32'h8000_0014;
		reload_wr = 1'b1;
		tick(1);
		reload_wr = 1'b0;
		tick(2);
		chk(timer, 32'h8000_0014);
		reload_data = 32'h0000_0028;
		reload_wr = 1'b1;
		tick(1);
		reload_wr = 1'b0;
		ctl[10:8] = 3'h3;
		fire(0);
		t1 = timer;
		chk(t1 < 32'h28 && t1 > 32'h10, 32'h1);
		chk(irq_req, 32'h0);
		tick(5);
		chk(timer, t1 - 32'h5);
		fire(4);
		chk(vector_num, 32'h4);
		clr(5'h10);
		wait_req();
		chk(timer, 32'h0);
		chk(req_pri, 32'h3);
		clr(5'h1f);
		ctl[10:8] = 3'h0;
		fire(0);
		chk(irq_req, 32'h1);
		clr(5'h1f);
		// Wake decisions
		go_sleep();
		chk(power_state, irq_coalesce_pkg::PWR_SLEEP);
		src_enable = 5'h1b;
		fire(2);
		chk(power_state, irq_coalesce_pkg::PWR_SLEEP);
		clr(5'h1f);
		src_enable = 5'h1f;
		base_pri = 6'h05;
		tick(2);
		fire(2);
		chk(power_state, irq_coalesce_pkg::PWR_IDLE);
		// Dropping the CPU priority lets the pending request leave IDLE
		base_pri = 6'h00;
		tick(3);
		chk(power_state, irq_coalesce_pkg::PWR_RUN);
		clr(5'h1f);
		go_sleep();
		chk(power_state, irq_coalesce_pkg::PWR_SLEEP);
		fire(3);
		chk(power_state, irq_coalesce_pkg::PWR_RUN);
		chk(irq_req, 32'h1);
		clr(5'h1f);
		ctl[10:8] = 3'h3;
		go_sleep();
		fire(0);
		chk(power_state, irq_coalesce_pkg::PWR_SLEEP);
		wait_req();
		tick(1);
		chk(power_state, irq_coalesce_pkg::PWR_RUN);
		clr(5'h1f);
		// Reset in mid-run from SLEEP with a flag standing
		go_sleep();
		src_enable = 5'h00;
		fire(1);
		chk(irq_flags, 32'h2);
		chk(power_state, irq_coalesce_pkg::PWR_SLEEP);
		resetn = 1'b0;
		tick(2);
		chk(irq_flags, 32'h0);
		chk(power_state, irq_coalesce_pkg::PWR_RUN);
		resetn = 1'b1;
		src_enable = 5'h1f;
		tick(2);
		chk(irq_req, 32'h0);
		chk(timer, 32'h0);
		results();
	end
endmodule
